// [hdl/dac_code_path.v]
// Channel code path of an eight-channel 14-bit converter with APB registers.
// Assumes an APB master on pclk and static strap pins for format and supply mode.
`timescale 1ns/100ps
`include "dac_code_consts.vh"
module dac_code_path #(
	// Factory trim values, straight binary; defaults are the nominal figures
	parameter [13:0] TRIM_A_G6 = `SHIFT_G6_BIN,
	parameter [13:0] TRIM_A_G4 = `SHIFT_G4_BIN,
	parameter [13:0] TRIM_B_G6 = `SHIFT_G6_BIN,
	parameter [13:0] TRIM_B_G4 = `SHIFT_G4_BIN
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Strap pins
	input wire number_format_select,
	input wire dual_supply,
	// Converter side
	output reg [14*`NUM_CHAN-1:0] chan_code,
	output reg [13:0] level_shift_code_a,
	output reg [13:0] level_shift_code_b,
	output reg shift_dac_powerdown,
	output reg gain_six
);
	// ****************************************
	// Declarations
	// ****************************************
	// Register file
	reg [13:0] input_q [0:`NUM_CHAN-1];
	reg [13:0] gain_q [0:`NUM_CHAN-1];
	reg [13:0] zero_q [0:`NUM_CHAN-1];
	reg [13:0] shift_a_q;
	reg [13:0] shift_b_q;
	// Control and strap state
	reg correction_enable;
	reg gain_sel_q;
	reg fmt_meta_q, fmt_q, sup_meta_q, sup_q;
	reg [1:0] init_cnt_q;
	// Next values of the level shift codes
	reg [13:0] shift_a_d;
	reg [13:0] shift_b_d;
	// Read path
	reg [31:0] rdata_d;
	reg rerr_d;
	// Bus qualifiers and decode
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr = access & pwrite & pready;
	wire [2:0] ch = paddr[4:2];
	wire init_busy = (init_cnt_q != 2'h0);
	wire init_load = (init_cnt_q == 2'h1);
	wire sel_config;
	wire sel_status;
	wire sel_shift_a;
	wire sel_shift_b;
	wire sel_input;
	wire sel_gain;
	wire sel_zero;
	wire sel_chan;
	wire wr_ok;
	wire gain_flip;
	wire [14*`NUM_CHAN-1:0] cal_bus;
	wire [14*`NUM_CHAN-1:0] bin_bus;
	integer i;

	// Region decode of an eight-word channel bank
	function in_bank;
		input [11:0] addr;
		input [11:0] base;
		begin
			in_bank = (addr[11:5] == base[11:5]) && (addr[1:0] == 2'b00);
		end
	endfunction

	// Sign bit flip between twos complement and offset binary
	function [13:0] flip_sign;
		input [13:0] code;
		input twos;
		begin
			flip_sign = code ^ (twos ? `CODE_MSB : 14'h0000);
		end
	endfunction

	// Level shift default for a group, converted to the external format
	function [13:0] shift_default;
		input six;
		input [13:0] t6;
		input [13:0] t4;
		input twos;
		begin
			shift_default = flip_sign(six ? t6 : t4, twos);
		end
	endfunction

	// ****************************************
	// Address decode
	// ****************************************
	// One select per register or bank; the read path uses all, the write path all but status and channel
	assign sel_config = (paddr == `OFF_CONFIG);
	assign sel_status = (paddr == `OFF_STATUS);
	assign sel_shift_a = (paddr == `OFF_SHIFT_A);
	assign sel_shift_b = (paddr == `OFF_SHIFT_B);
	assign sel_input = in_bank(paddr, `OFF_INPUT_BASE);
	assign sel_gain = in_bank(paddr, `OFF_GAIN_BASE);
	assign sel_zero = in_bank(paddr, `OFF_ZERO_BASE);
	assign sel_chan = in_bank(paddr, `OFF_CHAN_BASE);
	// Writes count only outside the start-up window
	assign wr_ok = wr & ~init_busy;
	assign gain_flip = wr_ok & sel_config & (pwdata[`CFG_GAIN_BIT] != gain_sel_q);

	// ****************************************
	// Strap synchronisers
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fmt_meta_q <= 1'b0;
			fmt_q <= 1'b0;
			sup_meta_q <= 1'b0;
			sup_q <= 1'b0;
		end else begin
			fmt_meta_q <= number_format_select;
			fmt_q <= fmt_meta_q;
			sup_meta_q <= dual_supply;
			sup_q <= sup_meta_q;
		end
	end

	// ****************************************
	// Start-up window
	// ****************************************
	// Three edges after release, so defaults load from synchronised straps
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt_q <= `INIT_CYCLES;
		end else if (init_busy) begin
			init_cnt_q <= init_cnt_q - 2'h1;
		end
	end

	// ****************************************
	// Per-channel format and calibration
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < `NUM_CHAN; g = g + 1) begin : chan
			wire [13:0] bin_code;
			// Input code to offset binary before arithmetic
			code_format fmt_in (
				.code_in(input_q[g]),
				.twos_mode(fmt_q),
				.code_out(bin_code)
			);
			// Gain unsigned, zero signed whatever the pin
			code_calibrate cal (
				.input_code(bin_code),
				.gain_code(gain_q[g]),
				.zero_code(zero_q[g]),
				.cal_code(cal_bus[14*g+13:14*g])
			);
			assign bin_bus[14*g+13:14*g] = bin_code;
		end
	endgenerate

	// ****************************************
	// Register writes
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < `NUM_CHAN; i = i + 1) begin
				input_q[i] <= `INPUT_RESET;
				gain_q[i] <= `GAIN_RESET;
				zero_q[i] <= `ZERO_RESET;
			end
			correction_enable <= 1'b0;
			gain_sel_q <= 1'b1;
			shift_a_q <= 14'h0000;
			shift_b_q <= 14'h0000;
		end else begin
			shift_a_q <= shift_a_d;
			shift_b_q <= shift_b_d;
			if (wr_ok) begin
				if (sel_config) begin
					correction_enable <= pwdata[`CFG_CORR_BIT];
					gain_sel_q <= pwdata[`CFG_GAIN_BIT];
				end else if (sel_input) begin
					input_q[ch] <= pwdata[13:0];
				end else if (sel_gain) begin
					gain_q[ch] <= pwdata[13:0];
				end else if (sel_zero) begin
					zero_q[ch] <= pwdata[13:0];
				end
			end
		end
	end

	// ****************************************
	// Level shift next value
	// ****************************************
	// Start-up load, gain reload or host write; stored in the written format
	always @* begin
		shift_a_d = shift_a_q;
		shift_b_d = shift_b_q;
		if (init_load) begin
			shift_a_d = shift_default(gain_sel_q, TRIM_A_G6, TRIM_A_G4, fmt_q);
			shift_b_d = shift_default(gain_sel_q, TRIM_B_G6, TRIM_B_G4, fmt_q);
		end else if (gain_flip) begin
			shift_a_d = shift_default(pwdata[`CFG_GAIN_BIT], TRIM_A_G6, TRIM_A_G4, fmt_q);
			shift_b_d = shift_default(pwdata[`CFG_GAIN_BIT], TRIM_B_G6, TRIM_B_G4, fmt_q);
		end else if (wr_ok && sel_shift_a) begin
			shift_a_d = pwdata[13:0];
		end else if (wr_ok && sel_shift_b) begin
			shift_b_d = pwdata[13:0];
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always @* begin
		rdata_d = 32'h0000_0000;
		rerr_d = 1'b0;
		if (sel_config) begin
			rdata_d = {30'h0000_0000, gain_sel_q, correction_enable};
		end else if (sel_status) begin
			rdata_d = {29'h0000_0000, init_busy, sup_q, fmt_q};
		end else if (sel_shift_a) begin
			rdata_d = {18'h0_0000, shift_a_q};
		end else if (sel_shift_b) begin
			rdata_d = {18'h0_0000, shift_b_q};
		end else if (sel_input) begin
			rdata_d = {18'h0_0000, input_q[ch]};
		end else if (sel_gain) begin
			rdata_d = {18'h0_0000, gain_q[ch]};
		end else if (sel_zero) begin
			rdata_d = {18'h0_0000, zero_q[ch]};
		end else if (sel_chan) begin
			rdata_d = {18'h0_0000, chan_code[14*ch +: 14]};
		end else begin
			rerr_d = 1'b1;
		end
	end

	// ****************************************
	// APB answer, no wait states
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			prdata <= (setup & ~pwrite) ? rdata_d : 32'h0000_0000;
			pslverr <= setup & rerr_d;
		end
	end

	// ****************************************
	// Converter-side outputs
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_code <= {14*`NUM_CHAN{1'b0}};
			level_shift_code_a <= 14'h0000;
			level_shift_code_b <= 14'h0000;
			shift_dac_powerdown <= 1'b1;
			gain_six <= 1'b1;
		end else begin
			chan_code <= correction_enable ? cal_bus : bin_bus;
			// Converter wants offset binary; stored value keeps written format
			level_shift_code_a <= flip_sign(shift_a_q, fmt_q);
			level_shift_code_b <= flip_sign(shift_b_q, fmt_q);
			shift_dac_powerdown <= ~sup_q;
			gain_six <= gain_sel_q;
		end
	end
endmodule // dac_code_path

// [hdl/dac_code_consts.vh]
// Constants for the channel code calibration and format block.
// Assumes inclusion by design files only; holds definitions alone.
`ifndef DAC_CODE_CONSTS_VH
`define DAC_CODE_CONSTS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define OFF_CONFIG 12'h000
`define OFF_STATUS 12'h004
`define OFF_SHIFT_A 12'h008
`define OFF_SHIFT_B 12'h00C
`define OFF_INPUT_BASE 12'h040
`define OFF_GAIN_BASE 12'h060
`define OFF_ZERO_BASE 12'h080
`define OFF_CHAN_BASE 12'h0A0
// ****************************************
// Config fields
// ****************************************
`define CFG_CORR_BIT 0
`define CFG_GAIN_BIT 1
// ****************************************
// Reset values and arithmetic constants
// ****************************************
`define GAIN_RESET 14'h2000
`define ZERO_RESET 14'h0000
`define INPUT_RESET 14'h0000
`define GAIN_BIAS 15'h2000
`define SHIFT_G6_BIN 14'h2666
`define SHIFT_G4_BIN 14'h2AAB
`define CODE_MSB 14'h2000
`define CODE_MAX 14'h3FFF
`define NUM_CHAN 8
`define INIT_CYCLES 2'h3
`endif

// [hdl/code_format.v]
// Converts a 14-bit code between the pin-selected external format and offset binary.
// Assumes a static format select level from the synchronised pin.
`timescale 1ns/100ps
`include "dac_code_consts.vh"
module code_format (
	// Code in and out
	input wire [13:0] code_in,
	input wire twos_mode,
	output wire [13:0] code_out
);
	// Twos complement maps to offset binary by flipping the sign bit
	assign code_out = twos_mode ? (code_in ^ `CODE_MSB) : code_in;
endmodule // code_format

// [hdl/code_calibrate.v]
// Combinational gain and zero correction of one offset-binary input code.
// Assumes gain unsigned and zero signed twos complement, per channel.
`timescale 1ns/100ps
`include "dac_code_consts.vh"
module code_calibrate (
	// Operands
	input wire [13:0] input_code,
	input wire [13:0] gain_code,
	input wire [13:0] zero_code,
	// Result
	output reg [13:0] cal_code
);
	reg [29:0] prod;
	reg signed [17:0] sum;
	// Scale by (gain + 2^13) / 2^14, add zero, saturate
	always @* begin
		prod = {16'h0000, input_code} * {15'h0000, ({1'b0, gain_code} + `GAIN_BIAS)};
		sum = $signed({2'b00, prod[29:14]}) + $signed({{4{zero_code[13]}}, zero_code});
		if (sum < 0) begin
			cal_code = 14'h0000;
		end else if (sum > $signed({4'h0, `CODE_MAX})) begin
			cal_code = `CODE_MAX;
		end else begin
			cal_code = sum[13:0];
		end
	end
endmodule // code_calibrate

// [sim/dac_code_path_sva.sv]
// Port-level assertions for the channel code path.
// Assumes binding onto dac_code_path with straps held steady outside reset.
`timescale 1ns/100ps
module dac_code_path_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Straps and converter side
	input wire logic number_format_select,
	input wire logic dual_supply,
	input wire logic [111:0] chan_code,
	input wire logic [13:0] level_shift_code_a,
	input wire logic [13:0] level_shift_code_b,
	input wire logic shift_dac_powerdown,
	input wire logic gain_six
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic corr_q;
	logic [13:0] exp_q;
	wire logic wr = psel && penable && pready && pwrite;
	// Track correction bit and expected channel 0 code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			corr_q <= 1'b0;
			exp_q <= 14'h0000;
		end else if (wr) begin
			if (paddr == 12'h000) corr_q <= pwdata[0];
			if (paddr == 12'h040) exp_q <= pwdata[13:0] ^ {number_format_select, 13'h0000};
		end
	end
	sequence s_setup; psel && !penable; endsequence
	sequence s_gain_flip; $changed(gain_six); endsequence
	a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
	a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_unmapped_err: assert property (psel && penable && pready && paddr >= 12'h0C0 |-> pslverr) else $error("no error");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:14] == 18'h0) else $error("upper bits set");
	a_pass_through: assert property (wr && paddr == 12'h040 && !corr_q |-> ##[2:3] chan_code[13:0] == exp_q)
		else $error("channel code not input code");
	a_shift_reload: assert property (s_gain_flip |-> ##[0:1] level_shift_code_a == (gain_six ? 14'h2666 : 14'h2AAB)
		&& level_shift_code_b == level_shift_code_a) else $error("level shift not reloaded");
	a_pwrdn_supply: assert property ($stable(dual_supply)[*5] |-> shift_dac_powerdown == !dual_supply)
		else $error("powerdown not following supply");
endmodule // dac_code_path_sva
bind dac_code_path dac_code_path_sva chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.number_format_select(number_format_select), .dual_supply(dual_supply), .chan_code(chan_code),
	.level_shift_code_a(level_shift_code_a), .level_shift_code_b(level_shift_code_b),
	.shift_dac_powerdown(shift_dac_powerdown), .gain_six(gain_six));

// [sim/apb_host.sv]
// Host processor model: APB master writing and reading codes.
// Assumes a slave that answers with pready; the bench timeout ends any hang.
`timescale 1ns/100ps
module apb_host (
	// Clock
	input wire logic pclk,
	// Request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	// Answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// One transfer, held until pready at an edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // Released data no longer valid
	endtask
	// Level shift codes are left at defaults except one write
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, d, q, e);
	endtask
	task rd(input logic [11:0] a, output logic [31:0] q, output logic e);
		xfer(1'b0, a, 32'h0000_0000, q, e);
	endtask
endmodule // apb_host

// [sim/tb.sv]
// Self-checking bench for the channel code path.
// Assumes the host model drives APB and the bench owns straps and reset.
`timescale 1ns/100ps
module tb;
	logic pclk = 1'b0, presetn = 1'b0, fmt = 1'b0, dual = 1'b1, err;
	logic psel, penable, pwrite, pready, pslverr, pwdn, gain_six;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [111:0] chan_code;
	logic [13:0] lsa, lsb;
	int num_errors = 0, checked = 0, cycles = 0;
	// Clock and timeout
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			end_of_test;
		end
	end
	dac_code_path DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.number_format_select(fmt), .dual_supply(dual), .chan_code(chan_code), .level_shift_code_a(lsa),
		.level_shift_code_b(lsb), .shift_dac_powerdown(pwdn), .gain_six(gain_six));
	apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	task end_of_test;
		if (num_errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] e);
		host.rd(a, rd, err);
		chk(rd, e);
	endtask
	task wchan(input logic [11:0] a, input logic [31:0] d, input logic [13:0] e, input int n);
		host.wr(a, d);
		repeat (2) @(posedge pclk);
		#1 chk(32'(chan_code[14*n+:14]), 32'(e));
	endtask
	task do_reset(input logic f, input logic d);
		@(posedge pclk);
		fmt <= f;
		dual <= d;
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask
	// Main sequence
	initial begin
		do_reset(1'b0, 1'b1);
		chk(32'({lsa, lsb}), 32'h0999_A666);
		chk(32'({pwdn, gain_six}), 32'h0000_0001);
		rchk(12'h060, 32'h0000_2000);
		rchk(12'h080, 32'h0000_0000);
		rchk(12'h040, 32'h0000_0000);
		rchk(12'h000, 32'h0000_0002);
		rchk(12'h008, 32'h0000_2666);
		rchk(12'h00C, 32'h0000_2666);
		rchk(12'h004, 32'h0000_0002);
		wchan(12'h040, 32'h0000_2000, 14'h2000, 0);
		wchan(12'h060, 32'h0000_0000, 14'h2000, 0);
		wchan(12'h080, 32'h0000_3FFF, 14'h2000, 0);
		rchk(12'h060, 32'h0000_0000);
		rchk(12'h080, 32'h0000_3FFF);
		wchan(12'h000, 32'h0000_0003, 14'h0FFF, 0);
		wchan(12'h040, 32'h0000_1234, 14'h0919, 0);
		host.wr(12'h064, 32'h0000_3FFF);
		wchan(12'h084, 32'h0000_1FFF, 14'h1FFF, 1);
		wchan(12'h044, 32'h0000_3FFF, 14'h3FFF, 1);
		wchan(12'h088, 32'h0000_2000, 14'h0000, 2);
		host.wr(12'h008, 32'h0000_0100);
		rchk(12'h008, 32'h0000_0100);
		host.wr(12'h000, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(32'({lsa, lsb}), 32'h0AAA_EAAB);
		chk(32'(gain_six), 32'h0000_0000);
		host.rd(12'h0FC, rd, err);
		chk({rd[30:0], err}, 32'h0000_0001);
		do_reset(1'b1, 1'b0);
		chk(32'(pwdn), 32'h0000_0001);
		chk(32'(chan_code[13:0]), 32'h0000_2000);
		rchk(12'h008, 32'h0000_0666);
		wchan(12'h040, 32'h0000_1FFF, 14'h3FFF, 0);
		wchan(12'h044, 32'h0000_2000, 14'h0000, 1);
		rchk(12'h040, 32'h0000_1FFF);
		rchk(12'h0A0, 32'h0000_3FFF);
		rchk(12'h004, 32'h0000_0001);
		end_of_test;
	end
endmodule // tb
